// ===== common/tisl_pkg.sv
// Types shared by the timer interrupt status logic.
// Assumes tisl_regs.svh supplies the widths.
`include "tisl_regs.svh"

package tisl_pkg;

  typedef logic [`TISL_FLAG_W-1:0] tisl_flags_t;

  // Register port request from software
  typedef struct packed {
    logic [`TISL_ADDR_W-1:0] addr;
    logic [31:0]             wdata;
    logic                    wr;
    logic                    rd;
  } tisl_bus_req_t;

  // Pulses from the timer event sources, one per flag position
  typedef struct packed {
    logic cb_event;
    logic cb_match;
    logic tb_timeout;
    logic clock_event;
    logic ca_event;
    logic ca_match;
    logic ta_timeout;
  } tisl_events_t;

  typedef struct packed {
    tisl_flags_t mask;
    tisl_flags_t raw;
    logic [31:0] rdata;
    logic        irq;
  } tisl_state_t;

endpackage

// ===== common/tisl_regs.svh
// Register offsets, field positions and reset values of the timer interrupt status logic.
// Assumes byte addresses on a 32-bit plain register port.
`ifndef TISL_REGS_SVH
`define TISL_REGS_SVH

`define TISL_ADDR_W           8
`define TISL_OFS_MASK         8'h18
`define TISL_OFS_RAW          8'h1C
`define TISL_OFS_MASKED       8'h20
`define TISL_OFS_CLEAR        8'h24

`define TISL_BIT_TA_TIMEOUT   0
`define TISL_BIT_CA_MATCH     1
`define TISL_BIT_CA_EVENT     2
`define TISL_BIT_CLOCK_EVENT  3
`define TISL_BIT_TB_TIMEOUT   8
`define TISL_BIT_CB_MATCH     9
`define TISL_BIT_CB_EVENT     10

`define TISL_FLAG_W           11
`define TISL_IMPL_BITS        11'h70F
`define TISL_MASK_RESET       11'h000
`define TISL_FLAGS_RESET      11'h000

`endif

// ===== src/tisl_top.sv
// Interrupt mask, raw flags and masked flags of a dual general-purpose timer.
// Assumes event pulses and the register port are synchronous to SYS_CLK_IN.
// Operation
// - The mask register holds one enable bit per source, one enables and zero disables it.
// - Mask bits sit at 10 cap-B event, 9 cap-B match, 8 tmr-B time-out, 3 clock, 2..0 cap-A/tmr-A.
// - Every mask bit resets to zero so all sources start disabled.
// - A raw flag is set by its event whatever the mask holds.
// - A raw flag stays set until software writes one to its clear bit.
// - The raw register is read-only and uses the mask's bit layout.
// - A masked flag reads set only when its source is enabled and its event has occurred.
// - Writing one to a clear bit also clears the masked flag.
// - The masked register is read-only with the raw register's layout.
// - The clear register is write-one-to-clear and writing zero has no effect.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "tisl_regs.svh"

module tisl_top (
  input  wire logic                  SYS_CLK_IN,
  input  wire logic                  RESET_N_IN,
  input  wire tisl_pkg::tisl_bus_req_t BUS_REQ_IN,
  input  wire tisl_pkg::tisl_events_t  EVENTS_IN,
  output logic [31:0]                BUS_RDATA_OUT,
  output logic                       IRQ_OUT
);
  import tisl_pkg::*;

  // Implemented flag positions; reserved bits read zero and ignore writes
  localparam tisl_flags_t IMPL_BITS   = `TISL_IMPL_BITS;
  localparam tisl_flags_t MASK_RESET  = `TISL_MASK_RESET;
  localparam tisl_flags_t FLAGS_RESET = `TISL_FLAGS_RESET;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  tisl_state_t  state_q;
  tisl_state_t  state_d;

  // Decoded strobes of the register port
  logic         mask_wr;
  logic         clear_wr;
  logic         mask_rd;
  logic         raw_rd;
  logic         masked_rd;
  logic         other_rd;

  // Flag vectors in register bit layout
  tisl_flags_t  set_vec;
  tisl_flags_t  clr_vec;
  tisl_flags_t  mask_nxt;
  tisl_flags_t  raw_nxt;
  tisl_flags_t  masked;

  // Per-source views in event order
  tisl_events_t enable_ev;
  tisl_events_t raw_ev;
  tisl_events_t next_ev;
  tisl_events_t masked_ev;

  // Enable bits by name
  logic         tmr_a_timeout_enable;
  logic         cap_a_match_enable;
  logic         cap_a_event_enable;
  logic         clock_event_enable;
  logic         tmr_b_timeout_enable;
  logic         cap_b_match_enable;
  logic         cap_b_event_enable;

  // Raw flags by name
  logic         tmr_a_timeout_raw;
  logic         cap_a_match_raw;
  logic         cap_a_event_raw;
  logic         clock_event_raw;
  logic         tmr_b_timeout_raw;
  logic         cap_b_match_raw;
  logic         cap_b_event_raw;

  // Next raw flags by name
  logic         tmr_a_timeout_next;
  logic         cap_a_match_next;
  logic         cap_a_event_next;
  logic         clock_event_next;
  logic         tmr_b_timeout_next;
  logic         cap_b_match_next;
  logic         cap_b_event_next;

  // Masked flags by name
  logic         tmr_a_timeout_masked;
  logic         cap_a_match_masked;
  logic         cap_a_event_masked;
  logic         clock_event_masked;
  logic         tmr_b_timeout_masked;
  logic         cap_b_match_masked;
  logic         cap_b_event_masked;

  // Packs per-source bits into the register bit layout
  function automatic tisl_flags_t pack_events(input tisl_events_t ev);
    tisl_flags_t f;
    f = '0;
    f[`TISL_BIT_TA_TIMEOUT]  = ev.ta_timeout;
    f[`TISL_BIT_CA_MATCH]    = ev.ca_match;
    f[`TISL_BIT_CA_EVENT]    = ev.ca_event;
    f[`TISL_BIT_CLOCK_EVENT] = ev.clock_event;
    f[`TISL_BIT_TB_TIMEOUT]  = ev.tb_timeout;
    f[`TISL_BIT_CB_MATCH]    = ev.cb_match;
    f[`TISL_BIT_CB_EVENT]    = ev.cb_event;
    return f;
  endfunction

  // Splits a register word back into per-source bits
  function automatic tisl_events_t unpack_flags(input tisl_flags_t f);
    tisl_events_t ev;
    ev.ta_timeout  = f[`TISL_BIT_TA_TIMEOUT];
    ev.ca_match    = f[`TISL_BIT_CA_MATCH];
    ev.ca_event    = f[`TISL_BIT_CA_EVENT];
    ev.clock_event = f[`TISL_BIT_CLOCK_EVENT];
    ev.tb_timeout  = f[`TISL_BIT_TB_TIMEOUT];
    ev.cb_match    = f[`TISL_BIT_CB_MATCH];
    ev.cb_event    = f[`TISL_BIT_CB_EVENT];
    return ev;
  endfunction

  // True when the request writes the given offset
  function automatic logic writes_to(
    input tisl_bus_req_t           req,
    input logic [`TISL_ADDR_W-1:0] ofs
  );
    return req.wr && (req.addr == ofs);
  endfunction

  // True when the request reads the given offset
  function automatic logic reads_from(
    input tisl_bus_req_t           req,
    input logic [`TISL_ADDR_W-1:0] ofs
  );
    return req.rd && (req.addr == ofs);
  endfunction

  // Keeps only implemented flag positions of a data word
  function automatic tisl_flags_t impl_field(input logic [31:0] word);
    return word[`TISL_FLAG_W-1:0] & IMPL_BITS;
  endfunction

  // Widens a flag word onto the data bus, upper bits zero
  function automatic logic [31:0] to_word(input tisl_flags_t f);
    return {{(32-`TISL_FLAG_W){1'b0}}, f};
  endfunction

  // True while any enabled flag is held
  function automatic logic any_masked(
    input tisl_flags_t raw,
    input tisl_flags_t mask
  );
    return |(raw & mask);
  endfunction

  always_comb begin
    mask_wr   = writes_to(BUS_REQ_IN, `TISL_OFS_MASK);
    clear_wr  = writes_to(BUS_REQ_IN, `TISL_OFS_CLEAR);
    mask_rd   = reads_from(BUS_REQ_IN, `TISL_OFS_MASK);
    raw_rd    = reads_from(BUS_REQ_IN, `TISL_OFS_RAW);
    masked_rd = reads_from(BUS_REQ_IN, `TISL_OFS_MASKED);
    other_rd  = BUS_REQ_IN.rd && !(mask_rd || raw_rd || masked_rd);
  end

  // Named views of the held enables and flags
  always_comb begin
    enable_ev = unpack_flags(state_q.mask);
    raw_ev    = unpack_flags(state_q.raw);

    tmr_a_timeout_enable = enable_ev.ta_timeout;
    cap_a_match_enable   = enable_ev.ca_match;
    cap_a_event_enable   = enable_ev.ca_event;
    clock_event_enable   = enable_ev.clock_event;
    tmr_b_timeout_enable = enable_ev.tb_timeout;
    cap_b_match_enable   = enable_ev.cb_match;
    cap_b_event_enable   = enable_ev.cb_event;

    tmr_a_timeout_raw = raw_ev.ta_timeout;
    cap_a_match_raw   = raw_ev.ca_match;
    cap_a_event_raw   = raw_ev.ca_event;
    clock_event_raw   = raw_ev.clock_event;
    tmr_b_timeout_raw = raw_ev.tb_timeout;
    cap_b_match_raw   = raw_ev.cb_match;
    cap_b_event_raw   = raw_ev.cb_event;
  end

  // One cell per source, so every flag follows the same set and clear law
  tisl_flag_cell u_ta_timeout (
    .enable_in    (tmr_a_timeout_enable),
    .raw_in       (tmr_a_timeout_raw),
    .event_in     (set_vec[`TISL_BIT_TA_TIMEOUT]),
    .clear_in     (clr_vec[`TISL_BIT_TA_TIMEOUT]),
    .raw_next_out (tmr_a_timeout_next),
    .masked_out   (tmr_a_timeout_masked)
  );

  tisl_flag_cell u_ca_match (
    .enable_in    (cap_a_match_enable),
    .raw_in       (cap_a_match_raw),
    .event_in     (set_vec[`TISL_BIT_CA_MATCH]),
    .clear_in     (clr_vec[`TISL_BIT_CA_MATCH]),
    .raw_next_out (cap_a_match_next),
    .masked_out   (cap_a_match_masked)
  );

  tisl_flag_cell u_ca_event (
    .enable_in    (cap_a_event_enable),
    .raw_in       (cap_a_event_raw),
    .event_in     (set_vec[`TISL_BIT_CA_EVENT]),
    .clear_in     (clr_vec[`TISL_BIT_CA_EVENT]),
    .raw_next_out (cap_a_event_next),
    .masked_out   (cap_a_event_masked)
  );

  tisl_flag_cell u_clock_event (
    .enable_in    (clock_event_enable),
    .raw_in       (clock_event_raw),
    .event_in     (set_vec[`TISL_BIT_CLOCK_EVENT]),
    .clear_in     (clr_vec[`TISL_BIT_CLOCK_EVENT]),
    .raw_next_out (clock_event_next),
    .masked_out   (clock_event_masked)
  );

  tisl_flag_cell u_tb_timeout (
    .enable_in    (tmr_b_timeout_enable),
    .raw_in       (tmr_b_timeout_raw),
    .event_in     (set_vec[`TISL_BIT_TB_TIMEOUT]),
    .clear_in     (clr_vec[`TISL_BIT_TB_TIMEOUT]),
    .raw_next_out (tmr_b_timeout_next),
    .masked_out   (tmr_b_timeout_masked)
  );

  tisl_flag_cell u_cb_match (
    .enable_in    (cap_b_match_enable),
    .raw_in       (cap_b_match_raw),
    .event_in     (set_vec[`TISL_BIT_CB_MATCH]),
    .clear_in     (clr_vec[`TISL_BIT_CB_MATCH]),
    .raw_next_out (cap_b_match_next),
    .masked_out   (cap_b_match_masked)
  );

  tisl_flag_cell u_cb_event (
    .enable_in    (cap_b_event_enable),
    .raw_in       (cap_b_event_raw),
    .event_in     (set_vec[`TISL_BIT_CB_EVENT]),
    .clear_in     (clr_vec[`TISL_BIT_CB_EVENT]),
    .raw_next_out (cap_b_event_next),
    .masked_out   (cap_b_event_masked)
  );

  // Gathers the cell outputs back into register words
  always_comb begin
    next_ev             = '0;
    next_ev.ta_timeout  = tmr_a_timeout_next;
    next_ev.ca_match    = cap_a_match_next;
    next_ev.ca_event    = cap_a_event_next;
    next_ev.clock_event = clock_event_next;
    next_ev.tb_timeout  = tmr_b_timeout_next;
    next_ev.cb_match    = cap_b_match_next;
    next_ev.cb_event    = cap_b_event_next;

    masked_ev             = '0;
    masked_ev.ta_timeout  = tmr_a_timeout_masked;
    masked_ev.ca_match    = cap_a_match_masked;
    masked_ev.ca_event    = cap_a_event_masked;
    masked_ev.clock_event = clock_event_masked;
    masked_ev.tb_timeout  = tmr_b_timeout_masked;
    masked_ev.cb_match    = cap_b_match_masked;
    masked_ev.cb_event    = cap_b_event_masked;

    raw_nxt = pack_events(next_ev);
    masked  = pack_events(masked_ev);
  end

  // Software side: writes to raw, masked and unmapped offsets are ignored
  always_comb begin
    set_vec  = pack_events(EVENTS_IN) & IMPL_BITS;
    clr_vec  = '0;
    mask_nxt = state_q.mask;
    if (clear_wr) begin
      clr_vec = impl_field(BUS_REQ_IN.wdata);
    end
    if (mask_wr) begin
      mask_nxt = impl_field(BUS_REQ_IN.wdata);
    end
  end

  // Irq registered so the line is glitch free toward the interrupt controller
  always_comb begin
    state_d      = state_q;
    state_d.mask = mask_nxt;
    state_d.raw  = raw_nxt;
    state_d.irq  = any_masked(raw_nxt, mask_nxt);

    state_d.rdata = WORD_ZERO;
    if (mask_rd) begin
      state_d.rdata = to_word(state_q.mask);
    end else if (raw_rd) begin
      state_d.rdata = to_word(state_q.raw);
    end else if (masked_rd) begin
      state_d.rdata = to_word(masked);
    end else if (other_rd) begin
      // Unmapped offsets read zero
      state_d.rdata = WORD_ZERO;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q.mask  <= MASK_RESET;
      state_q.raw   <= FLAGS_RESET;
      state_q.rdata <= WORD_ZERO;
      state_q.irq   <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign BUS_RDATA_OUT = state_q.rdata;
  assign IRQ_OUT       = state_q.irq;

endmodule

// Combinational step of one source: sticky raw flag and its masked view
module tisl_flag_cell (
  input  wire logic enable_in,
  input  wire logic raw_in,
  input  wire logic event_in,
  input  wire logic clear_in,
  output logic      raw_next_out,
  output logic      masked_out
);
  import tisl_pkg::*;

  // Set beats clear so an event in the clearing cycle is not lost
  function automatic logic sticky_next(
    input logic held,
    input logic fire,
    input logic wipe
  );
    return (held & ~wipe) | fire;
  endfunction

  always_comb begin
    raw_next_out = sticky_next(raw_in, event_in, clear_in);
    masked_out   = raw_in & enable_in;
  end

endmodule

// ===== test/tisl_checker.sv
// Checks the interrupt status ports of tisl_top.
// Assumes it is bound to tisl_top and sees only its ports.
`timescale 1ns/1ps
module tisl_checker (
  input logic                    SYS_CLK_IN,
  input logic                    RESET_N_IN,
  input tisl_pkg::tisl_bus_req_t BUS_REQ_IN,
  input tisl_pkg::tisl_events_t  EVENTS_IN,
  input logic [31:0]             BUS_RDATA_OUT,
  input logic                    IRQ_OUT
);
  logic [10:0] m_q;
  wire [7:0] a = BUS_REQ_IN.addr;
  wire w = BUS_REQ_IN.wr, r = BUS_REQ_IN.rd;
  wire [10:0] ev = {EVENTS_IN[6:4], 4'h0, EVENTS_IN[3:0]};
  // Mask mirror, since no internal state is visible here
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN) m_q <= 11'h000;
    else if (w && a == 8'h18) m_q <= BUS_REQ_IN.wdata[10:0] & 11'h70F;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_idle; !r |=> BUS_RDATA_OUT == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_rsvd; r |=> BUS_RDATA_OUT[31:11] == 21'h0 && BUS_RDATA_OUT[7:4] == 4'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_mask; r && a == 8'h18 |=> BUS_RDATA_OUT[10:0] == $past(m_q); endproperty
  a_mask: assert property (p_mask) else $error("mask readback");
  property p_msk; r && a == 8'h20 |=> (BUS_RDATA_OUT[10:0] & ~$past(m_q)) == 11'h0; endproperty
  a_msk: assert property (p_msk) else $error("masked flag not enabled");
  property p_set; (ev & m_q) != 11'h0 && !(w && a == 8'h18) |=> IRQ_OUT; endproperty
  a_set: assert property (p_set) else $error("irq missing");
  property p_off; m_q == 11'h0 && !(w && a == 8'h18) |=> !IRQ_OUT; endproperty
  a_off: assert property (p_off) else $error("irq with empty mask");
  property p_fall; $fell(IRQ_OUT) |-> $past(w && (a == 8'h24 || a == 8'h18)); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped alone");
  property p_rise; $rose(IRQ_OUT) |-> $past(ev != 11'h0 || (w && a == 8'h18)); endproperty
  a_rise: assert property (p_rise) else $error("irq without cause");
  c_clr: cover property (w && a == 8'h24);
  c_irq: cover property ($rose(IRQ_OUT));
  c_msk: cover property (r && a == 8'h20);
endmodule
bind tisl_top tisl_checker chk (.SYS_CLK_IN, .RESET_N_IN, .BUS_REQ_IN, .EVENTS_IN,
  .BUS_RDATA_OUT, .IRQ_OUT);

// ===== test/tisl_evsrc.sv
// Timer event sources: one-cycle pulses per source.
// Assumes the bench picks the sources just after an edge.
`timescale 1ns/1ps
module tisl_evsrc (
  input  logic                   clk_in,
  input  logic [6:0]             fire_in,
  output tisl_pkg::tisl_events_t ev_out = '0
);
  // Launched on the edge so each pulse is one clean cycle
  always @(posedge clk_in) ev_out <= fire_in;
endmodule

// ===== test/tisl_top_tb.sv
// Bench: register calls on the plain port with expected words.
// Assumes tisl_evsrc fires the timer events.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s %h %h", n, e, g); end end
module tisl_top_tb;
  import tisl_pkg::*;
  logic          c = 1'h0, rn = 1'h0, i;
  logic [6:0]    f = 7'h00;
  logic [31:0]   d;
  tisl_bus_req_t q = '0;
  tisl_events_t  ev;
  int            num_errors = 0, comparisons = 0;
  always #25 c = ~c;
  tisl_evsrc src (.clk_in(c), .fire_in(f), .ev_out(ev));
  tisl_top dut (.SYS_CLK_IN(c), .RESET_N_IN(rn), .BUS_REQ_IN(q), .EVENTS_IN(ev),
    .BUS_RDATA_OUT(d), .IRQ_OUT(i));
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge c) q <= {a, v, 2'h2};
    @(posedge c) q <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge c) q <= {a, 32'h0, 2'h1};
    @(posedge c) q <= '0;
    #1 `CHK("rdata", e, d)
  endtask
  task automatic end_sim;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge c);
    rn <= 1'h1;
    rd(8'h18, 32'h0);
    @(posedge c) f <= 7'h7F;
    @(posedge c) f <= 7'h00;
    rd(8'h1C, 32'h70F);
    rd(8'h20, 32'h0);
    rd(8'h10, 32'h0);
    $display("test raw done");
    wr(8'h18, 32'hFFFFFFFF);
    wr(8'h1C, 32'h0);
    rd(8'h18, 32'h70F);
    rd(8'h20, 32'h70F);
    `CHK("irq", 1'h1, i)
    wr(8'h24, 32'h0);
    wr(8'h24, 32'h00F);
    rd(8'h1C, 32'h700);
    rd(8'h20, 32'h700);
    wr(8'h24, 32'h700);
    rd(8'h1C, 32'h0);
    `CHK("irq", 1'h0, i)
    $display("test clear done");
    end_sim();
  end
  initial begin
    repeat (200) @(posedge c);
    num_errors++;
    end_sim();
  end
endmodule
